// File: core/general_purpose_timers.sv
// Standalone 16-bit timer and a chainable pair of 16-bit timers
// Function
// - Standalone 16-bit timer, four counting modes
// - Flag on period match or gate fall
// - Run bit 15 starts and stops
// - Bit 13 halts timer in idle
// - Bit 6 gating, internal clock only
// - Prescale codes divide by 1/8/64/256
// - Bit 2 synchronises external clock
// - Bit 1 selects external pin clock
// - Unimplemented control bits read zero
// - Pair timers lack asynchronous counting
// - Pair timers synchronous, gated, prescaled
// - Chained: low word first timer
// - Chained: second control ignored entirely
// - Chained: interrupt uses second flag
// - Chained period from both period registers
// - Chained count across both count registers
// - Chained 32-bit timer or counter
// - Pair supplies time base outward
// - ADC trigger only from chained pair
// - Bit 3 chains pair into 32-bit
`timescale 1ns/1ps

module general_purpose_timers (
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	input  wire logic [timer_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [timer_pkg::DATA_W-1:0]  regWdata,
	input  wire logic                          regWrite,
	input  wire logic                          regRead,
	output logic      [timer_pkg::DATA_W-1:0]  regRdata,
	input  wire logic                          idleMode,
	input  wire logic                          standaloneExtClockPin,
	input  wire logic                          pairLowExtClockPin,
	input  wire logic                          pairHighExtClockPin,
	input  wire logic                          standaloneGatePin,
	input  wire logic                          pairLowGatePin,
	input  wire logic                          pairHighGatePin,
	output logic      [timer_pkg::NUM_TIMERS-1:0] irqRequest,
	output logic      [timer_pkg::PRIO_W-1:0]  standaloneIrqPriority,
	output logic      [timer_pkg::PRIO_W-1:0]  pairLowIrqPriority,
	output logic      [timer_pkg::PRIO_W-1:0]  pairHighIrqPriority,
	output logic      [timer_pkg::DATA_W-1:0]  timeBaseLow,
	output logic      [timer_pkg::DATA_W-1:0]  timeBaseHigh,
	output logic                               adcTrigger
);
	import timer_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [PRE_W-1:0] preLast(input logic [1:0] sel);
		logic [PRE_W-1:0] r;
		r = PRE_LAST_1;
		unique case (sel)
			PS_DIV1:   r = PRE_LAST_1;
			PS_DIV8:   r = PRE_LAST_8;
			PS_DIV64:  r = PRE_LAST_64;
			PS_DIV256: r = PRE_LAST_256;
		endcase
		return r;
	endfunction

	function automatic logic isWrite(input logic we,
		input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		return we && (a == off);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	logic [DATA_W-1:0]     ctl_q  [NUM_TIMERS];
	logic [DATA_W-1:0]     cnt_q  [NUM_TIMERS];
	logic [DATA_W-1:0]     per_q  [NUM_TIMERS];
	logic [PRE_W-1:0]      pre_q  [NUM_TIMERS];
	logic [NUM_TIMERS-1:0] flag_q;
	logic [DATA_W-1:0]     irqCfg_q;
	logic [DATA_W-1:0]     rdata_q;
	logic                  adcTrigger_q;

	logic [NUM_TIMERS-1:0] clkS1_q;
	logic [NUM_TIMERS-1:0] clkS2_q;
	logic [NUM_TIMERS-1:0] clkS3_q;
	logic [NUM_TIMERS-1:0] clkS4_q;
	logic [NUM_TIMERS-1:0] gateS1_q;
	logic [NUM_TIMERS-1:0] gateS2_q;
	logic [NUM_TIMERS-1:0] gateS3_q;
	logic                  idleS1_q;
	logic                  idleS2_q;

	logic [NUM_TIMERS-1:0] srcTick;
	logic [NUM_TIMERS-1:0] tick;
	logic [NUM_TIMERS-1:0] gatedMode;
	logic [NUM_TIMERS-1:0] gateFall;
	logic [NUM_TIMERS-1:0] match16;
	logic [NUM_TIMERS-1:0] hit;
	logic [NUM_TIMERS-1:0] cntWrite;
	logic                  chain;
	logic                  match32;
	logic [2*DATA_W-1:0]   count32;
	logic [2*DATA_W-1:0]   count32Next;
	logic [DATA_W-1:0]     rdata_d;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	// Pins come from outside the clock domain; two flops before any use
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clkS1_q  <= '0;
			clkS2_q  <= '0;
			clkS3_q  <= '0;
			clkS4_q  <= '0;
			gateS1_q <= '0;
			gateS2_q <= '0;
			gateS3_q <= '0;
			idleS1_q <= 1'b0;
			idleS2_q <= 1'b0;
		end else begin
			clkS1_q  <= {pairHighExtClockPin, pairLowExtClockPin,
				standaloneExtClockPin};
			clkS2_q  <= clkS1_q;
			clkS3_q  <= clkS2_q;
			clkS4_q  <= clkS3_q;
			gateS1_q <= {pairHighGatePin, pairLowGatePin, standaloneGatePin};
			gateS2_q <= gateS1_q;
			gateS3_q <= gateS2_q;
			idleS1_q <= idleMode;
			idleS2_q <= idleS1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Count sources

	assign chain = ctl_q[T_LOW][CHAIN_BIT];

	always_comb begin
		for (int i = 0; i < NUM_TIMERS; i++) begin
			logic run;
			logic ext;
			logic edgeSeen;
			run = 1'b0;
			ext = 1'b0;
			edgeSeen = 1'b0;
			run = ctl_q[i][RUN_BIT] && !(ctl_q[i][IDLE_BIT] && idleS2_q);
			ext = ctl_q[i][SRC_BIT];
			if (i == T_SOLO && !ctl_q[i][SYNC_BIT])
				edgeSeen = clkS2_q[i] && !clkS3_q[i];
			else
				edgeSeen = clkS3_q[i] && !clkS4_q[i];
			gatedMode[i] = run && !ext && ctl_q[i][GATE_BIT];
			gateFall[i]  = !gateS2_q[i] && gateS3_q[i];
			if (!run)
				srcTick[i] = 1'b0;
			else if (ext)
				srcTick[i] = edgeSeen;
			else if (gatedMode[i])
				srcTick[i] = gateS2_q[i];
			else
				srcTick[i] = 1'b1;
			tick[i] = srcTick[i] &&
				(pre_q[i] == preLast(ctl_q[i][PRE_HI:PRE_LO]));
			match16[i] = (cnt_q[i] == per_q[i]);
		end
	end

	// Prescaler restarts on a control write so a new ratio starts clean
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_TIMERS; i++)
				pre_q[i] <= PRE_RESET;
		end else begin
			for (int i = 0; i < NUM_TIMERS; i++) begin
				if (regWrite && regAddr == OFF_SOLO_CTL + 4'(3 * i))
					pre_q[i] <= PRE_RESET;
				else if (tick[i])
					pre_q[i] <= PRE_RESET;
				else if (srcTick[i])
					pre_q[i] <= pre_q[i] + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counters

	assign count32 = {cnt_q[T_HIGH], cnt_q[T_LOW]};
	assign match32 = (count32 == {per_q[T_HIGH], per_q[T_LOW]});
	assign count32Next = match32 ? '0 : count32 + 32'h0000_0001;

	always_comb begin
		for (int i = 0; i < NUM_TIMERS; i++)
			cntWrite[i] = isWrite(regWrite, regAddr,
				OFF_SOLO_CNT + 4'(3 * i));
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_TIMERS; i++)
				cnt_q[i] <= CNT_RESET;
		end else begin
			if (cntWrite[T_SOLO])
				cnt_q[T_SOLO] <= regWdata;
			else if (tick[T_SOLO])
				cnt_q[T_SOLO] <= match16[T_SOLO] ? '0
					: cnt_q[T_SOLO] + 16'h0001;
			if (chain) begin
				// chained runs on low timer ticks
				if (cntWrite[T_LOW])
					cnt_q[T_LOW] <= regWdata;
				else if (tick[T_LOW])
					cnt_q[T_LOW] <= count32Next[DATA_W-1:0];
				if (cntWrite[T_HIGH])
					cnt_q[T_HIGH] <= regWdata;
				else if (tick[T_LOW])
					cnt_q[T_HIGH] <= count32Next[2*DATA_W-1:DATA_W];
			end else begin
				for (int i = T_LOW; i <= T_HIGH; i++) begin
					if (cntWrite[i])
						cnt_q[i] <= regWdata;
					else if (tick[i])
						cnt_q[i] <= match16[i] ? '0 : cnt_q[i] + 16'h0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt flags and ADC trigger

	always_comb begin
		for (int i = 0; i < NUM_TIMERS; i++) begin
			hit[i] = gatedMode[i] ? gateFall[i] : (tick[i] && match16[i]);
		end
		if (chain) begin
			hit[T_LOW]  = 1'b0;
			hit[T_HIGH] = gatedMode[T_LOW] ? gateFall[T_LOW]
				: (tick[T_LOW] && match32);
		end
	end

	// Set wins over a simultaneous software clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			flag_q <= '0;
		else if (regWrite && regAddr == OFF_IRQ_FLAG)
			flag_q <= hit | (flag_q & ~regWdata[NUM_TIMERS-1:0]);
		else
			flag_q <= hit | flag_q;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			adcTrigger_q <= 1'b0;
		else
			adcTrigger_q <= chain && tick[T_LOW] && match32;
	end

	////////////////////////////////////////////////////////////////////////
	// Register file

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_TIMERS; i++) begin
				ctl_q[i] <= CTL_RESET;
				per_q[i] <= PER_RESET;
			end
			irqCfg_q <= IRQ_RESET;
		end else if (regWrite) begin
			unique case (regAddr)
				OFF_SOLO_CTL: ctl_q[T_SOLO] <= regWdata & SOLO_CTL_MASK;
				OFF_LOW_CTL:  ctl_q[T_LOW]  <= regWdata & LOW_CTL_MASK;
				OFF_HIGH_CTL: ctl_q[T_HIGH] <= regWdata & HIGH_CTL_MASK;
				OFF_SOLO_PER: per_q[T_SOLO] <= regWdata;
				OFF_LOW_PER:  per_q[T_LOW]  <= regWdata;
				OFF_HIGH_PER: per_q[T_HIGH] <= regWdata;
				OFF_IRQ_CFG:  irqCfg_q <= regWdata & IRQ_CFG_MASK;
				default: ;
			endcase
		end
	end

	always_comb begin
		rdata_d = '0;
		unique case (regAddr)
			OFF_SOLO_CTL: rdata_d = ctl_q[T_SOLO];
			OFF_SOLO_CNT: rdata_d = cnt_q[T_SOLO];
			OFF_SOLO_PER: rdata_d = per_q[T_SOLO];
			OFF_LOW_CTL:  rdata_d = ctl_q[T_LOW];
			OFF_LOW_CNT:  rdata_d = cnt_q[T_LOW];
			OFF_LOW_PER:  rdata_d = per_q[T_LOW];
			OFF_HIGH_CTL: rdata_d = ctl_q[T_HIGH];
			OFF_HIGH_CNT: rdata_d = cnt_q[T_HIGH];
			OFF_HIGH_PER: rdata_d = per_q[T_HIGH];
			OFF_IRQ_FLAG: rdata_d = {13'h0000, flag_q};
			OFF_IRQ_CFG:  rdata_d = irqCfg_q;
			default:      rdata_d = '0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rdata_q <= '0;
		else if (regRead)
			rdata_q <= rdata_d;
		else
			rdata_q <= '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign regRdata   = rdata_q;
	assign irqRequest = flag_q & irqCfg_q[IRQ_EN_LO +: NUM_TIMERS];
	assign standaloneIrqPriority = irqCfg_q[PRIO_POS0 +: PRIO_W];
	assign pairLowIrqPriority    = irqCfg_q[PRIO_POS1 +: PRIO_W];
	assign pairHighIrqPriority   = irqCfg_q[PRIO_POS2 +: PRIO_W];
	assign timeBaseLow  = cnt_q[T_LOW];
	assign timeBaseHigh = cnt_q[T_HIGH];
	assign adcTrigger   = adcTrigger_q;

endmodule

// File: core/timer_pkg.sv
// Constants shared by the general-purpose timer block
package timer_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int NUM_TIMERS = 3;
	localparam int PRE_W = 8;
	localparam int PRIO_W = 3;

	// Timer indices
	localparam int T_SOLO = 0;
	localparam int T_LOW  = 1;
	localparam int T_HIGH = 2;

	// Register word addresses
	localparam logic [3:0] OFF_SOLO_CTL  = 4'h0;
	localparam logic [3:0] OFF_SOLO_CNT  = 4'h1;
	localparam logic [3:0] OFF_SOLO_PER  = 4'h2;
	localparam logic [3:0] OFF_LOW_CTL   = 4'h3;
	localparam logic [3:0] OFF_LOW_CNT   = 4'h4;
	localparam logic [3:0] OFF_LOW_PER   = 4'h5;
	localparam logic [3:0] OFF_HIGH_CTL  = 4'h6;
	localparam logic [3:0] OFF_HIGH_CNT  = 4'h7;
	localparam logic [3:0] OFF_HIGH_PER  = 4'h8;
	localparam logic [3:0] OFF_IRQ_FLAG  = 4'h9;
	localparam logic [3:0] OFF_IRQ_CFG   = 4'hA;

	// Control field positions
	localparam int RUN_BIT   = 15;
	localparam int IDLE_BIT  = 13;
	localparam int GATE_BIT  = 6;
	localparam int PRE_HI    = 5;
	localparam int PRE_LO    = 4;
	localparam int CHAIN_BIT = 3;
	localparam int SYNC_BIT  = 2;
	localparam int SRC_BIT   = 1;

	// Interrupt configuration field positions
	localparam int IRQ_EN_LO = 0;
	localparam int PRIO_POS0 = 4;
	localparam int PRIO_POS1 = 8;
	localparam int PRIO_POS2 = 12;
	localparam logic [15:0] IRQ_CFG_MASK = 16'h7777;

	// Implemented bits of each control register
	localparam logic [15:0] SOLO_CTL_MASK = 16'hA076;
	localparam logic [15:0] LOW_CTL_MASK  = 16'hA07A;
	localparam logic [15:0] HIGH_CTL_MASK = 16'hA072;

	// Values after reset
	localparam logic [15:0] CTL_RESET    = 16'h0000;
	localparam logic [15:0] CNT_RESET    = 16'h0000;
	localparam logic [15:0] PER_RESET    = 16'hFFFF;
	localparam logic [15:0] IRQ_RESET    = 16'h0000;
	localparam logic [7:0]  PRE_RESET    = 8'h00;

	// Prescale codes and terminal counts
	localparam logic [1:0] PS_DIV1   = 2'h0;
	localparam logic [1:0] PS_DIV8   = 2'h1;
	localparam logic [1:0] PS_DIV64  = 2'h2;
	localparam logic [1:0] PS_DIV256 = 2'h3;
	localparam logic [7:0] PRE_LAST_1   = 8'h00;
	localparam logic [7:0] PRE_LAST_8   = 8'h07;
	localparam logic [7:0] PRE_LAST_64  = 8'h3F;
	localparam logic [7:0] PRE_LAST_256 = 8'hFF;

endpackage

// File: testbench/ext_pins_model.sv
// External clock and gate pins seen by the timers
`timescale 1ns/1ps
module ext_pins_model (
	input  wire logic clk,
	output logic      extClk,
	output logic      gate
);
	initial begin
		extClk = 1'b0;
		gate = 1'b0;
	end
	// Clock stands still between bursts; gap sets the speed
	task automatic pulses(input int n, input int gap);
		repeat (n) begin
			repeat (gap) @(posedge clk);
			extClk <= 1'b1;
			repeat (gap) @(posedge clk);
			extClk <= 1'b0;
		end
	endtask
	task automatic setGate(input logic val);
		@(posedge clk);
		gate <= val;
	endtask
endmodule

// File: testbench/general_purpose_timers_asserts.sv
// Port-level assertions for the timer block
`timescale 1ns/1ps
module general_purpose_timers_asserts import timer_pkg::*; (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [3:0]  regAddr,
	input wire logic [15:0] regWdata,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [15:0] regRdata,
	input wire logic [2:0]  irqRequest,
	input wire logic [2:0]  standaloneIrqPriority,
	input wire logic [2:0]  pairHighIrqPriority,
	input wire logic [15:0] timeBaseLow,
	input wire logic        adcTrigger
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	ctl_mask_a: assert property (regRead && regAddr == OFF_SOLO_CTL
		|=> (regRdata & ~SOLO_CTL_MASK) == 16'h0) else $error("solo mask");
	pair_mask_a: assert property (regRead && regAddr == OFF_LOW_CTL
		|=> (regRdata & ~LOW_CTL_MASK) == 16'h0) else $error("pair mask");
	prio_cfg_a: assert property (regWrite && regAddr == OFF_IRQ_CFG
		|=> pairHighIrqPriority == $past(regWdata[14:12])
		&& standaloneIrqPriority == $past(regWdata[6:4]))
		else $error("priority field");
	irq_off_a: assert property (regWrite && regAddr == OFF_IRQ_CFG
		&& regWdata[2:0] == 3'h0 |=> irqRequest == 3'h0)
		else $error("masked request");
	// Flags leave only through a register write
	irq_hold_a: assert property ($fell(irqRequest[0])
		|-> $past(regWrite)) else $error("flag dropped");
	adc_pulse_a: assert property (adcTrigger |=> !adcTrigger)
		else $error("trigger width");
	adc_wrap_a: assert property (adcTrigger |-> timeBaseLow == 16'h0
		|| $past(timeBaseLow) == 16'h0 || $past(timeBaseLow, 2) == 16'h0)
		else $error("trigger without wrap");
	count_step_a: assert property ($changed(timeBaseLow)
		|-> timeBaseLow == $past(timeBaseLow) + 16'h1
		|| timeBaseLow == 16'h0 || $past(regWrite)) else $error("count jump");
endmodule

bind general_purpose_timers general_purpose_timers_asserts
	general_purpose_timers_asserts_i (.clk, .reset_n, .regAddr, .regWdata,
	.regWrite, .regRead, .regRdata, .irqRequest, .standaloneIrqPriority,
	.pairHighIrqPriority, .timeBaseLow, .adcTrigger);

// File: testbench/general_purpose_timers_bench.sv
// Self-checking bench for the general-purpose timers
`timescale 1ns/1ps
module general_purpose_timers_bench;
	import timer_pkg::*;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWdata = 16'h0;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic        idleMode = 1'b0;
	logic [15:0] regRdata, timeBaseLow, timeBaseHigh, v;
	logic [2:0]  irqRequest, soloPrio, lowPrio, highPrio;
	logic        adcTrigger, extClk, gate, sawHigh;
	logic [15:0] msk[3] = '{SOLO_CTL_MASK, LOW_CTL_MASK, HIGH_CTL_MASK};
	int          sh[4] = '{0, 3, 6, 8};
	int          miscompares = 0;
	int          samplesChecked = 0;
	int          cycles = 0;
	int          adcCount = 0;
	int          seed = 32'hB06212BA;
	int          n, k, p;

	always #50 clk = ~clk;

	general_purpose_timers general_purpose_timers_i (.clk, .reset_n,
		.regAddr, .regWdata, .regWrite, .regRead, .regRdata, .idleMode,
		.standaloneExtClockPin(extClk), .pairLowExtClockPin(extClk),
		.pairHighExtClockPin(extClk), .standaloneGatePin(gate),
		.pairLowGatePin(gate), .pairHighGatePin(gate), .irqRequest,
		.standaloneIrqPriority(soloPrio), .pairLowIrqPriority(lowPrio),
		.pairHighIrqPriority(highPrio), .timeBaseLow, .timeBaseHigh,
		.adcTrigger);
	ext_pins_model ext_pins_model_i (.clk, .extClk, .gate);

	task automatic summarize;
		if (miscompares == 0 && samplesChecked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, s);
		samplesChecked++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		// One idle edge so a following write never reassigns the strobe
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 v = regRdata;
		@(posedge clk);
	endtask
	// Sync stages and stop latency leave one count of slack
	function automatic logic [15:0] near(int e, logic [15:0] s);
		return 16'(!$isunknown(s) && int'(s) >= e - 1 && int'(s) <= e + 1);
	endfunction

	always @(posedge clk) begin
		cycles++;
		if (adcTrigger === 1'b1)
			adcCount++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 16; a++) begin
			rd(4'(a));
			chk("reset", (a % 3 == 2 && a < 9) ? PER_RESET : 16'h0, v);
		end
		for (int i = 0; i < 3; i++) begin
			wr(4'(3 * i), 16'hFFFF);
			rd(4'(3 * i));
			chk("ctlMask", msk[i], v);
			wr(4'(3 * i), 16'h0);
		end
		for (int b = 0; b < 6; b += 3) begin
			for (int ps = 0; ps < 4; ps++) begin
				k = 2 + ($unsigned($random(seed)) % 4);
				wr(4'(b + 1), 16'h0);
				wr(4'(b), 16'h8000 | 16'(ps << 4));
				repeat ((k << sh[ps]) - 1) @(posedge clk);
				wr(4'(b), 16'h0);
				rd(4'(b + 1));
				chk("prescale", 16'h1, near(k, v));
			end
		end
		idleMode <= 1'b1;
		for (int h = 0; h < 2; h++) begin
			wr(OFF_SOLO_CNT, 16'h0);
			wr(OFF_SOLO_CTL, h ? 16'hA000 : 16'h8000);
			repeat (39) @(posedge clk);
			wr(OFF_SOLO_CTL, 16'h0);
			rd(OFF_SOLO_CNT);
			chk("idle", 16'h1, near(h ? 0 : 41, v));
		end
		idleMode <= 1'b0;
		v = 16'($random(seed)) & IRQ_CFG_MASK | 16'h7;
		wr(OFF_IRQ_CFG, v);
		chk("soloPrio", 16'(v[PRIO_POS0 +: PRIO_W]), 16'(soloPrio));
		chk("lowPrio", 16'(v[PRIO_POS1 +: PRIO_W]), 16'(lowPrio));
		chk("highPrio", 16'(v[PRIO_POS2 +: PRIO_W]), 16'(highPrio));
		p = 3 + ($unsigned($random(seed)) % 8);
		wr(OFF_SOLO_PER, 16'(p));
		wr(OFF_IRQ_FLAG, 16'h7);
		wr(OFF_SOLO_CNT, 16'h0);
		wr(OFF_SOLO_CTL, 16'h8000);
		repeat (p + 4) @(posedge clk);
		wr(OFF_SOLO_CTL, 16'h0);
		repeat (5) @(posedge clk);
		chk("sticky", 16'h1, 16'(irqRequest[0]));
		rd(OFF_SOLO_CNT);
		chk("wrap", 16'h1, 16'(v <= p));
		wr(OFF_IRQ_FLAG, 16'h1);
		wr(OFF_SOLO_PER, 16'hFFFF);
		wr(OFF_SOLO_CNT, 16'h0);
		chk("cleared", 16'h0, 16'(irqRequest[0]));
		wr(OFF_SOLO_CTL, 16'h8040);
		repeat (20) @(posedge clk);
		ext_pins_model_i.setGate(1'b1);
		repeat (30) @(posedge clk);
		ext_pins_model_i.setGate(1'b0);
		repeat (6) @(posedge clk);
		chk("gateFall", 16'h1, 16'(irqRequest[0]));
		rd(OFF_SOLO_CNT);
		chk("gated", 16'h1, near(31, v));
		for (int i = 0; i < 3; i++) begin
			n = 2 + ($unsigned($random(seed)) % 5);
			wr(i < 2 ? OFF_SOLO_CNT : OFF_LOW_CNT, 16'h0);
			wr(i < 2 ? OFF_SOLO_CTL : OFF_LOW_CTL, i == 1 ? 16'h8046 : 16'h8042);
			ext_pins_model_i.pulses(n, 2 + i);
			repeat (6) @(posedge clk);
			rd(i < 2 ? OFF_SOLO_CNT : OFF_LOW_CNT);
			chk("extCount", 16'(n), v);
			wr(i < 2 ? OFF_SOLO_CTL : OFF_LOW_CTL, 16'h0);
		end
		chk("adcAlone", 16'h0, 16'(adcCount));
		wr(OFF_IRQ_FLAG, 16'h7);
		wr(OFF_HIGH_CTL, 16'h2030);
		wr(OFF_LOW_PER, 16'h5);
		wr(OFF_HIGH_PER, 16'h1);
		wr(OFF_LOW_CNT, 16'hFFF8);
		wr(OFF_HIGH_CNT, 16'h0);
		idleMode <= 1'b1;
		wr(OFF_LOW_CTL, 16'h8008);
		sawHigh = 1'b0;
		n = 0;
		while (adcTrigger !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1 n++;
			if (timeBaseHigh === 16'h1)
				sawHigh = 1'b1;
		end
		chk("highWord", 16'h1, 16'(sawHigh));
		chk("wrapHigh", 16'h0, timeBaseHigh);
		chk("chainIrq", 16'h4, 16'(irqRequest));
		chk("adcTime", 16'h1, 16'(n >= 12 && n <= 18));
		@(posedge clk);
		wr(OFF_LOW_CTL, 16'h0);
		wr(OFF_IRQ_CFG, 16'h0);
		wr(OFF_SOLO_CTL, 16'h8000);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(OFF_SOLO_CTL);
		chk("ctlReset", CTL_RESET, v);
		summarize();
	end
endmodule
